// ---- core/ncrs_host.sv ----
// file: host sequencer for pipelined cache page reads of a nand flash
`timescale 1ns/1ns
`default_nettype none

// Function
// - first page address starts at column zero; host sends zero columns.
// - cache read command only after normal read shows ready.
// - next page address optional; otherwise device reads next sequential page.
// - last-page command ends the sequence without another fetch.
// - no sequential cache command after highest device page.
// - keep a cache read sequence within one block when required.
// - wait at least 10 us after power-up before any command.
// - hold write-protect low during power-up and power-down; the host drives wp_n low only in ST_PWRUP, with nothing for power-down.
// - at most 8 partial programs per page.
// - completion seen on ready/busy pin or status bit 6.
// - status command makes each read cycle return the status byte.
module ncrs_host
  import ncrs_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // user request: start a cache read run of page_count pages
  input  wire logic              start,
  input  wire logic [ROW_W-1:0]  start_row,
  input  wire logic [6:0]        page_count,
  input  wire logic              use_status_poll,
  output logic                   start_ready,
  // page data stream out
  output logic                   data_valid,
  output logic [7:0]             data_byte,
  output logic                   page_last,
  input  wire logic              data_ready,
  // completion and fault
  output logic                   run_done,
  output logic                   timeout_err,
  // flash pins
  output ncrs_pins_type          pins,
  input  wire logic [7:0]        io_in,
  input  wire logic              rb_in
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0]
  {
    ST_PWRUP   = 4'b0000,
    ST_IDLE    = 4'b0001,
    ST_RD_CMD  = 4'b0010,
    ST_RD_ADR  = 4'b0011,
    ST_RD_CONF = 4'b0100,
    ST_WAIT    = 4'b0101,
    ST_CACHE   = 4'b0110,
    ST_POLLCMD = 4'b0111,
    ST_POLLRD  = 4'b1000,
    ST_STREAM  = 4'b1001,
    ST_DONE    = 4'b1010
  } ncrs_state_type;

  ncrs_state_type   state_r, state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [ROW_W-1:0] row_r;
  logic [6:0]       left_r;
  logic [2:0]       adr_idx_r;
  logic [11:0]      col_r;
  logic             last_cmd_r;
  logic             poll_r;
  logic             err_r;
  logic             done_r;
  logic [7:0]       io_s1_r, io_s2_r;
  logic             rb_s1_r, rb_s2_r;

  // two-stage synchronisers for asynchronous pins
  always_ff @(posedge sys_clk)
  begin
    io_s1_r <= io_in;
    io_s2_r <= io_s1_r;
    rb_s1_r <= rb_in;
    rb_s2_r <= rb_s1_r;
  end

  // ---------------------------------------------------------------
  // bus cycle engine
  // ---------------------------------------------------------------
  ncrs_cyc_req_type cyc_req;
  logic             cyc_valid, cyc_ready, cyc_done;
  logic [7:0]       cyc_rd;
  logic             p_cle, p_ale, p_we_n, p_re_n, p_oe;
  logic [7:0]       p_io;

  ncrs_bus_cycle u_cyc
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .req_valid  (cyc_valid),
    .req        (cyc_req),
    .req_ready  (cyc_ready),
    .done       (cyc_done),
    .rd_data    (cyc_rd),
    .io_in_sync (io_s2_r),
    .cle        (p_cle),
    .ale        (p_ale),
    .we_n       (p_we_n),
    .re_n       (p_re_n),
    .io_out     (p_io),
    .io_oe      (p_oe)
  );

  // decode of the current step
  wire in_cyc_w     = (state_r != ST_PWRUP) && (state_r != ST_IDLE)
                      && (state_r != ST_WAIT) && (state_r != ST_DONE);
  wire idle_cyc_w   = cyc_ready && !cyc_done;
  wire ready_stat_w = cyc_rd[READY_STATUS_BIT];
  wire dev_ready_w  = poll_r ? (state_r == ST_POLLRD && cyc_done && ready_stat_w)
                             : rb_s2_r;
  wire [5:0] page_w = row_r[5:0];
  // first cache command copies row_r itself, later ones copy row_r + 1
  wire first_last_w = (left_r == 7'd1) || (page_w == LAST_PAGE_IN_BLOCK)
                      || (row_r == LAST_ROW);
  wire want_last_w  = (left_r <= 7'd2) || (page_w == LAST_PAGE_IN_BLOCK - 6'd1)
                      || (row_r == LAST_ROW - 18'd1);
  wire tmr_exp_w    = (tmr_r == '0);
  wire page_end_w   = (col_r == 12'(PAGE_BYTES - 1));

  // address byte: two zero column bytes, then three row bytes
  logic [7:0] adr_byte_w;
  always_comb
  begin
    case (adr_idx_r)
      3'd0, 3'd1: adr_byte_w = 8'h00;
      3'd2:       adr_byte_w = row_r[7:0];
      3'd3:       adr_byte_w = row_r[15:8];
      default:    adr_byte_w = {6'h00, row_r[17:16]};
    endcase
  end

  // cycle request selection; read-type commands only, no page is ever programmed
  always_comb
  begin
    cyc_valid = 1'b0;
    cyc_req   = '{kind: NCRS_CYC_CMD, data: 8'h00};
    case (state_r)
      ST_RD_CMD:  begin cyc_valid = idle_cyc_w; cyc_req.data = CMD_READ_SETUP; end
      ST_RD_ADR:  begin cyc_valid = idle_cyc_w; cyc_req = '{NCRS_CYC_ADDR, adr_byte_w}; end
      ST_RD_CONF: begin cyc_valid = idle_cyc_w; cyc_req.data = CMD_READ_CONF; end
      // no address sent, so the device takes the next sequential page
      ST_CACHE:   begin cyc_valid = idle_cyc_w;
                    cyc_req.data = last_cmd_r ? CMD_CACHE_LAST : CMD_CACHE_SEQ; end
      ST_POLLCMD: begin cyc_valid = idle_cyc_w; cyc_req.data = CMD_STATUS; end
      ST_POLLRD:  begin cyc_valid = idle_cyc_w; cyc_req.kind = NCRS_CYC_READ; end
      ST_STREAM:  begin cyc_valid = idle_cyc_w && data_ready; cyc_req.kind = NCRS_CYC_READ; end
      default:    cyc_valid = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_PWRUP:   if (tmr_exp_w) state_nxt = ST_IDLE;
      ST_IDLE:    if (start && page_count != 7'd0) state_nxt = ST_RD_CMD;
      ST_RD_CMD:  if (cyc_done) state_nxt = (adr_idx_r == 3'd7) ? ST_STREAM : ST_RD_ADR;
      ST_RD_ADR:  if (cyc_done && adr_idx_r == 3'd4) state_nxt = ST_RD_CONF;
      ST_RD_CONF: if (cyc_done) state_nxt = poll_r ? ST_POLLCMD : ST_WAIT;
      ST_WAIT:    if (tmr_exp_w) state_nxt = ST_DONE;
                  else if (dev_ready_w && tmr_r < TMR_W'(READ_LAT_CYC - 2))
                    state_nxt = ST_CACHE;
      ST_CACHE:   if (cyc_done) state_nxt = poll_r ? ST_POLLCMD : ST_WAIT;
      ST_POLLCMD: if (cyc_done) state_nxt = ST_POLLRD;
      ST_POLLRD:  if (tmr_exp_w) state_nxt = ST_DONE;
                  else if (dev_ready_w)
                    state_nxt = ST_CACHE;
      ST_STREAM:  if (cyc_done && page_end_w)
                    state_nxt = (left_r == 7'd1 || last_cmd_r) ? ST_DONE : ST_CACHE;
      ST_DONE:    state_nxt = ST_IDLE;
      default:    state_nxt = ST_IDLE;
    endcase
    // the first ready after a cache command leads to data readout; status
    // mode must be left with the read command first, or reads return status
    if ((state_r == ST_WAIT || state_r == ST_POLLRD) && state_nxt == ST_CACHE
        && adr_idx_r == 3'd7)
      state_nxt = poll_r ? ST_RD_CMD : ST_STREAM;
    if (state_r == ST_WAIT && state_nxt == ST_CACHE && poll_r)
      state_nxt = ST_WAIT;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // adr_idx 7 marks "a cache command is outstanding", so ready means read data
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r    <= ST_PWRUP;
      tmr_r      <= TMR_W'(POWER_UP_CYC);
      row_r      <= '0;
      left_r     <= 7'd0;
      adr_idx_r  <= 3'd0;
      col_r      <= 12'd0;
      last_cmd_r <= 1'b0;
      poll_r     <= 1'b0;
      err_r      <= 1'b0;
      done_r     <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      done_r  <= (state_r == ST_DONE);
      if (!tmr_exp_w)
        tmr_r <= tmr_r - TMR_W'(1);
      if (state_r == ST_IDLE && state_nxt == ST_RD_CMD)
      begin
        row_r     <= {start_row[ROW_W-1:6], 6'h00} | start_row;
        left_r    <= page_count;
        poll_r    <= use_status_poll;
        adr_idx_r <= 3'd0;
        err_r     <= 1'b0;
      end
      if (state_r == ST_RD_ADR && cyc_done && adr_idx_r != 3'd4)
        adr_idx_r <= adr_idx_r + 3'd1;
      // every busy wait is bounded by the array read latency
      if (state_nxt == ST_WAIT || state_nxt == ST_POLLCMD)
        if (state_r != ST_WAIT && state_r != ST_POLLRD && state_r != ST_POLLCMD)
          tmr_r <= TMR_W'(READ_LAT_CYC);
      // last_cmd_r is kept, so the page after a last-page command ends the run
      if (state_r == ST_CACHE && cyc_done)
        adr_idx_r <= 3'd7;
      if (state_r == ST_RD_CONF && cyc_done)
      begin
        adr_idx_r  <= 3'd0;
        last_cmd_r <= first_last_w;
      end
      if (state_nxt == ST_STREAM && state_r != ST_STREAM)
      begin
        adr_idx_r <= 3'd0;
        col_r     <= 12'd0;
      end
      if (state_r == ST_STREAM && cyc_done)
      begin
        col_r <= page_end_w ? 12'd0 : col_r + 12'd1;
        if (page_end_w)
        begin
          left_r     <= left_r - 7'd1;
          row_r      <= row_r + ROW_W'(1);
          last_cmd_r <= want_last_w;
        end
      end
      if (tmr_exp_w && (state_r == ST_WAIT || state_r == ST_POLLRD))
        err_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign start_ready = (state_r == ST_IDLE);
  assign data_valid  = (state_r == ST_STREAM) && cyc_done;
  assign data_byte   = cyc_rd;
  assign page_last   = data_valid && page_end_w;
  assign run_done    = done_r;
  assign timeout_err = err_r;
  // write protect held low until the power-up wait ends
  assign pins = '{ce_n:   !in_cyc_w && state_r != ST_WAIT,
                  cle:    p_cle,
                  ale:    p_ale,
                  we_n:   p_we_n,
                  re_n:   p_re_n,
                  wp_n:   (state_r != ST_PWRUP),
                  io_out: p_io,
                  io_oe:  p_oe};

endmodule

`default_nettype wire

// ---- core/ncrs_pkg.sv ----
// package: constants and carrier types for the cache read sequencer host
package ncrs_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS       = 100;
  localparam int unsigned POWER_UP_WAIT_US    = 10;
  localparam int unsigned ARRAY_READ_LAT_US   = 25;
  localparam int unsigned PROG_MAX_US         = 700;
  localparam int unsigned DUMMY_BUSY_MAX_US   = 1;
  localparam int unsigned WIPE_MAX_MS         = 2;
  localparam int unsigned POWER_UP_CYC  = (POWER_UP_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;
  localparam int unsigned READ_LAT_CYC  = (ARRAY_READ_LAT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC      = (PROG_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned DUMMY_CYC     = (DUMMY_BUSY_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WIPE_CYC      = (WIPE_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 16;

  // ---------------------------------------------------------------
  // geometry and status
  // ---------------------------------------------------------------
  localparam int unsigned PAGE_BYTES      = 2112;
  localparam int unsigned PAGES_PER_BLOCK = 64;
  localparam int unsigned BLOCK_COUNT     = 4096;
  localparam int unsigned GOOD_BLOCK_MIN  = 4016;
  localparam int unsigned PARTIAL_WRITE_LIMIT = 8;
  localparam int unsigned READY_STATUS_BIT    = 6;
  localparam int unsigned COL_W  = 12;
  localparam int unsigned ROW_W  = 18;
  localparam logic [5:0]  LAST_PAGE_IN_BLOCK = 6'h3F;
  localparam logic [17:0] LAST_ROW           = 18'h3_FFFF;

  // ---------------------------------------------------------------
  // command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONF  = 8'h30;
  localparam logic [7:0] CMD_CACHE_SEQ  = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_STATUS     = 8'h70;

  // bus cycle kinds handed to the pin driver
  typedef enum logic [1:0]
  {
    NCRS_CYC_CMD  = 2'b00,
    NCRS_CYC_ADDR = 2'b01,
    NCRS_CYC_READ = 2'b10
  } ncrs_cyc_type;

  typedef struct packed
  {
    ncrs_cyc_type kind;
    logic [7:0]   data;
  } ncrs_cyc_req_type;

  // pin bundle towards the flash
  typedef struct packed
  {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic [7:0] io_out;
    logic       io_oe;
  } ncrs_pins_type;

endpackage

// ---- core/ncrs_bus_cycle.sv ----
// file: one flash bus cycle (command, address or read) generator
`timescale 1ns/1ns
`default_nettype none

module ncrs_bus_cycle
  import ncrs_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // request from the sequencer
  input  wire logic             req_valid,
  input  wire ncrs_cyc_req_type req,
  output logic                  req_ready,
  output logic                  done,
  output logic [7:0]            rd_data,
  // pins, io input already synchronised
  input  wire logic [7:0]       io_in_sync,
  output logic                  cle,
  output logic                  ale,
  output logic                  we_n,
  output logic                  re_n,
  output logic [7:0]            io_out,
  output logic                  io_oe
);

  // ---------------------------------------------------------------
  // four-phase cycle: setup, strobe low, strobe high (a read keeps re_n low through both), release
  // ---------------------------------------------------------------
  logic [1:0]   phase_r;
  logic         busy_r;
  ncrs_cyc_type kind_r;
  logic [7:0]   data_r;
  logic [7:0]   rd_r;
  logic         done_r;

  // one 100 ns phase covers every setup, pulse and hold minimum
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      busy_r  <= 1'b0;
      phase_r <= 2'd0;
      kind_r  <= NCRS_CYC_CMD;
      data_r  <= 8'h00;
      rd_r    <= 8'h00;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (!busy_r && req_valid)
      begin
        busy_r  <= 1'b1;
        phase_r <= 2'd0;
        kind_r  <= req.kind;
        data_r  <= req.data;
      end
      else if (busy_r)
      begin
        phase_r <= phase_r + 2'd1;
        // the two pin flops lag two edges, so the strobe value arrives in phase 3
        if (phase_r == 2'd3 && kind_r == NCRS_CYC_READ)
          rd_r <= io_in_sync;
        if (phase_r == 2'd3)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  // pin decode
  wire strobe_w = busy_r && (phase_r == 2'd1 || phase_r == 2'd2);
  assign req_ready = !busy_r;
  assign done      = done_r;
  assign rd_data   = rd_r;
  assign cle       = busy_r && kind_r == NCRS_CYC_CMD;
  assign ale       = busy_r && kind_r == NCRS_CYC_ADDR;
  assign we_n      = !(strobe_w && phase_r == 2'd1 && kind_r != NCRS_CYC_READ);
  assign re_n      = !(strobe_w && kind_r == NCRS_CYC_READ);
  assign io_out    = data_r;
  assign io_oe     = busy_r && kind_r != NCRS_CYC_READ;

endmodule

`default_nettype wire

// ---- tb/ncrs_host_monitor.sv ----
// checker: port-level assertions for the cache read sequencer host
`timescale 1ns/1ns
`default_nettype none

module ncrs_host_monitor
  import ncrs_pkg::*;
(
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  // user side
  input wire logic             start,
  input wire logic [ROW_W-1:0] start_row,
  input wire logic [6:0]       page_count,
  input wire logic             use_status_poll,
  input wire logic             start_ready,
  input wire logic             data_valid,
  input wire logic [7:0]       data_byte,
  input wire logic             page_last,
  input wire logic             data_ready,
  input wire logic             run_done,
  input wire logic             timeout_err,
  // flash side
  input wire ncrs_pins_type    pins,
  input wire logic [7:0]       io_in,
  input wire logic             rb_in
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic [7:0] pu_cnt_r;
  logic [8:0] lo_cnt_r;
  wire        take = start && start_ready && (page_count != 7'h00);

  // cycles since reset release, and length of the current busy stretch (saturating)
  always_ff @(posedge sys_clk)
  begin
    pu_cnt_r <= rst ? 8'h00 : pu_cnt_r + {7'h00, pu_cnt_r != 8'hFF};
    lo_cnt_r <= (rst || rb_in) ? 9'h000 : lo_cnt_r + {8'h00, lo_cnt_r != 9'h1FF};
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_reset_pins_idle: assert property (disable iff (1'b0) rst |=> pins.ce_n && pins.we_n
    && pins.re_n && !pins.io_oe && !pins.wp_n && !start_ready) else $error("pins not idle in reset");
  chk_powerup_hold: assert property (pu_cnt_r < 8'h62 |-> !start_ready && pins.ce_n
    && !pins.wp_n) else $error("command before power-up wait");
  chk_cmd_latch_shape: assert property (pins.cle |-> !pins.ale && pins.io_oe
    && !pins.ce_n && pins.re_n) else $error("bad command cycle");
  chk_read_released: assert property (!pins.re_n |-> !pins.io_oe && pins.we_n
    && !pins.ce_n) else $error("host drives io while reading");
  chk_we_one_cycle: assert property ($fell(pins.we_n) |=> pins.we_n)
    else $error("write strobe too long");
  chk_read_after_ready: assert property (!use_status_poll && $fell(pins.re_n) |-> $past(rb_in, 2))
    else $error("data read while busy");
  chk_busy_timeout: assert property (lo_cnt_r == 9'h104 |-> ##[0:4] timeout_err)
    else $error("busy overrun not flagged");
  chk_no_early_timeout: assert property ($rose(timeout_err) |-> $past(lo_cnt_r) >= 9'h0F0)
    else $error("timeout flagged too early");
  chk_run_done_pulse: assert property (run_done |=> !run_done)
    else $error("run done longer than one cycle");
  chk_start_taken: assert property (take |=> !start_ready ##1 !timeout_err)
    else $error("start not taken cleanly");
  chk_last_with_valid: assert property (page_last |-> data_valid)
    else $error("page end without byte");

  cover property (take && use_status_poll);
  cover property ($rose(timeout_err));
  cover property (page_last ##[1:400] run_done);
  cover property (!data_ready ##1 data_valid);
endmodule

bind ncrs_host ncrs_host_monitor i_ncrs_host_monitor (.sys_clk, .rst, .start, .start_row,
  .page_count, .use_status_poll, .start_ready, .data_valid, .data_byte, .page_last,
  .data_ready, .run_done, .timeout_err, .pins, .io_in, .rb_in);

`default_nettype wire

// ---- tb/ncrs_flash_model.sv ----
// model: behavioural cache-read flash answering the host pins
`timescale 1ns/1ns
`default_nettype none

module ncrs_flash_model
  import ncrs_pkg::*;
(
  // clock used to sample the pins and to count down busy time
  input  wire logic          sys_clk,
  // host pins and busy length chosen by the bench
  input  wire ncrs_pins_type pins,
  input  wire logic [15:0]   busy_cyc,
  // device outputs
  output logic [7:0]         io_in,
  output logic               rb_in
);
  // ---------------------------------------------------------------
  // array, cache and status state
  // ---------------------------------------------------------------
  logic [17:0] page_row_r  = '0;
  logic [17:0] fetch_row_r = '0;
  logic [11:0] col_r       = '0;
  logic [39:0] addr_r      = '0;
  logic [2:0]  acnt_r      = '0;
  logic [15:0] busy_r      = '0;
  logic        stat_r      = 1'b0;
  logic        we_d_r      = 1'b1;
  logic        re_d_r      = 1'b1;
  logic [7:0]  pat;
  wire         cmd_wr = pins.we_n && !we_d_r && !pins.ce_n && pins.cle;
  wire         adr_wr = pins.we_n && !we_d_r && !pins.ce_n && pins.ale;

  // page pattern; released lines show its inverse so no stale value survives
  assign pat   = page_row_r[7:0] ^ col_r[7:0] ^ {4'h0, col_r[11:8]};
  assign rb_in = (busy_r == 16'h0000);
  assign io_in = (pins.re_n || pins.ce_n) ? ~pat :
                 stat_r ? {pins.wp_n, rb_in, 1'b1, 5'h00} : pat;

  // no program or erase modelled: every block reads good, busy only per read
  // any command other than status read leaves status mode, as the real part does
  always @(posedge sys_clk)
  begin
    we_d_r <= pins.we_n;
    re_d_r <= pins.re_n;
    if (busy_r != 16'h0000)
      busy_r <= busy_r - 16'h0001;
    if (pins.re_n && !re_d_r && !stat_r)
      col_r <= col_r + 12'h001;
    if (adr_wr)
      addr_r[acnt_r*8 +: 8] <= pins.io_out;
    if (adr_wr)
      acnt_r <= acnt_r + 3'h1;
    if (cmd_wr)
      stat_r <= (pins.io_out == CMD_STATUS);
    if (cmd_wr && pins.io_out == CMD_READ_SETUP)
      acnt_r <= 3'h0;
    if (cmd_wr && pins.io_out == CMD_READ_CONF)
    begin
      fetch_row_r <= addr_r[33:16];
      col_r <= addr_r[11:0];
      busy_r <= busy_cyc;
    end
    if (cmd_wr && (pins.io_out == CMD_CACHE_SEQ || pins.io_out == CMD_CACHE_LAST))
    begin
      page_row_r <= fetch_row_r;
      col_r <= 12'h000;
      busy_r <= busy_cyc;
    end
    // only the sequential command starts the next fetch
    if (cmd_wr && pins.io_out == CMD_CACHE_SEQ)
      fetch_row_r <= fetch_row_r + 18'h0_0001;
  end
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// testbench: cache read runs of the host against the flash model
`timescale 1ns/1ns
`default_nettype none

module tb;
  import ncrs_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  logic             start = 1'b0;
  logic             use_status_poll = 1'b0;
  logic             data_ready = 1'b1;
  logic             stall_en = 1'b0;
  logic [ROW_W-1:0] start_row = '0;
  logic [6:0]       page_count = 7'h00;
  logic [15:0]      busy_cyc = 16'h0028;
  wire logic        start_ready, data_valid, page_last, run_done, timeout_err, rb_in;
  wire logic [7:0]  data_byte, io_in;
  wire ncrs_pins_type pins;
  int               failures = 0;
  int               compares = 0;

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;
  // consumer readiness, toggled while stalling
  always @(posedge sys_clk) data_ready <= stall_en ? ~data_ready : 1'b1;

  ncrs_host i_ncrs_host (.sys_clk, .rst, .start, .start_row, .page_count, .use_status_poll,
    .start_ready, .data_valid, .data_byte, .page_last, .data_ready, .run_done, .timeout_err,
    .pins, .io_in, .rb_in);
  ncrs_flash_model i_ncrs_flash_model (.sys_clk, .pins, .busy_cyc, .io_in, .rb_in);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // bounded wait on a falling edge: 0 byte strobe, 1 run end, 2 device ready
  task automatic wait_on(input int sel, input int lim);
    do
      @(negedge sys_clk);
    while (((sel == 0) ? data_valid : (sel == 1) ? run_done : rb_in) !== 1'b1 && --lim > 0);
  endtask

  task automatic launch(input logic [17:0] row, input logic [6:0] n, input logic poll,
                        input logic [15:0] bcyc);
    int lim;
    lim = 0;
    while (start_ready !== 1'b1 && lim < 300)
    begin
      @(negedge sys_clk);
      lim++;
    end
    @(posedge sys_clk);
    start_row <= row;
    page_count <= n;
    use_status_poll <= poll;
    busy_cyc <= bcyc;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
  endtask

  // every byte of n pages in ascending row order, then the end pulse
  task automatic read_pages(input logic [17:0] row, input int n);
    logic [11:0] col;
    logic [7:0]  rlo;
    for (int p = 0; p < n; p++)
      for (int c = 0; c < PAGE_BYTES; c++)
      begin
        col = 12'(c);
        rlo = row[7:0] + 8'(p);
        wait_on(0, 800);
        check(data_byte, {24'h0, rlo ^ col[7:0] ^ {4'h0, col[11:8]}}, "byte");
        check(page_last, c == PAGE_BYTES - 1, "page end");
      end
    wait_on(1, 400);
    check(run_done, 1'b1, "run end");
  endtask

  // one page on the ready pin, consumer stalling every other cycle
  task automatic sc_single;
    stall_en = 1'b1;
    launch(18'h0_0000, 7'h01, 1'b0, 16'h0028);
    read_pages(18'h0_0000, 1);
    check(timeout_err, 1'b0, "no timeout");
    stall_en = 1'b0;
  endtask

  // three pages by status polling with a slow device: 30h, 31h, 31h, 3Fh
  task automatic sc_poll;
    launch(18'h0_0105, 7'h03, 1'b1, 16'h00C8);
    read_pages(18'h0_0105, 3);
    check(timeout_err, 1'b0, "slow not timeout");
  endtask

  // device stuck busy beyond the array read latency
  task automatic sc_timeout;
    launch(18'h0_0200, 7'h02, 1'b0, 16'h012C);
    wait_on(1, 800);
    check(run_done, 1'b1, "abort end");
    check(timeout_err, 1'b1, "timeout flag");
    wait_on(2, 600);
  endtask

  // last two rows of the device, flag cleared by the new start
  task automatic sc_dev_end;
    launch(LAST_ROW - 18'h0_0001, 7'h02, 1'b0, 16'h0028);
    repeat (2) @(negedge sys_clk);
    check(timeout_err, 1'b0, "flag cleared");
    read_pages(LAST_ROW - 18'h0_0001, 2);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (50) @(negedge sys_clk);
    check(start_ready, 1'b0, "power-up wait");
    check(pins.wp_n, 1'b0, "wp low at power-up");
    sc_single;
    sc_poll;
    sc_timeout;
    sc_dev_end;
    complete_run;
  end

  // about six page times of traffic fit well inside this span
  initial
  begin
    repeat (95000) @(posedge sys_clk);
    failures++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run;
  end
endmodule

`default_nettype wire
